/* rtl/lme_pkg.sv */
`default_nettype none

package lme_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LANES  = 4;

  // Word addresses of the register slice
  localparam logic [15:0] TX_ERROR_FLAGS_ADDR      = 16'h0090;
  localparam logic [15:0] TX_ERROR_IRQ_ENABLE_ADDR = 16'h0091;
  localparam logic [15:0] RX_LINK_CONTROL_ADDR     = 16'h00c2;
  localparam logic [15:0] RX_ERROR_FLAGS_ADDR      = 16'h00d0;

  // Transmit flag and enable bit positions (same layout in both registers)
  localparam int unsigned TX_BURST_GAP_BIT  = 6;
  localparam int unsigned TX_ECC_FATAL_BIT  = 5;
  localparam int unsigned TX_ECC_CORR_BIT   = 4;
  localparam int unsigned TX_ADAPT_OVF_BIT  = 3;
  localparam int unsigned TX_ALIGN_LOST_BIT = 2;
  localparam int unsigned TX_PHY_UNF_BIT    = 1;
  localparam int unsigned TX_PHY_OVF_BIT    = 0;
  localparam int unsigned TX_W              = 7;

  // Receive control and flag positions
  localparam int unsigned RX_REINIT_BIT     = 0;
  localparam int unsigned RX_ALIGN_LOST_BIT = 6;
  localparam int unsigned RX_W              = 11;
  localparam logic [10:0] RX_FLAG_VALID     = 11'h77e;

  // Values after reset
  localparam logic [6:0]  TX_FLAGS_RST  = 7'h00;
  localparam logic [6:0]  TX_EN_RST     = 7'h48;
  localparam logic        REINIT_RST    = 1'b0;
  localparam logic [10:0] RX_FLAGS_RST  = 11'h000;

  // Minimum idle cycles between two bursts on the user side
  localparam logic [7:0]  BURST_GAP     = 8'h04;

  // Receive lane alignment states
  typedef enum logic [1:0] {
    LME_IDLE    = 2'b00,
    LME_SEEK    = 2'b01,
    LME_ALIGNED = 2'b10
  } lme_align_e;

endpackage : lme_pkg

`default_nettype wire

/* rtl/lme_regs.sv */
// Summary of operation
// - Any lane's rate-adaptation FIFO overflow sets transmit flag bit 3.
// - Loss of lane alignment on any transmit lane sets transmit flag bit 2.
// - Any lane's phase-compensation FIFO underflow sets transmit flag bit 1.
// - Any lane's phase-compensation FIFO overflow sets transmit flag bit 0.
// - Flags clear only by writing one; writing zero keeps them; reset clears all.
// - Enable bit 6 gates the burst-spacing interrupt, read-write, resets to one.
// - Enable bit 5 gates the double-bit memory error interrupt, resets to zero.
// - Enable bit 4 gates the single-bit memory error interrupt, resets to zero.
// - Enable bit 3 gates the adaptation FIFO overflow interrupt, resets to one.
// - Enable bit 2 gates the lane alignment loss interrupt, resets to zero.
// - Enable bit 1 gates the phase FIFO underflow interrupt, resets to zero.
// - Enable bit 0 gates the phase FIFO overflow interrupt, resets to zero.
// - Receive control bit 0 is read-write, resets zero, requests link re-initialization.
// - While restart is set, alignment machine sits idle, then aligns again.
// - Burst spacing below the minimum on the user input sets flag bit 6.
// - Uncorrected double-bit error sets bit 5; corrected single-bit error sets bit 4.
//
// The plain strobed port was decided locally.
`default_nettype none

module lme_regs (
  // Clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           resetn,
  // Register port
  input  wire logic [lme_pkg::ADDR_W-1:0]     addr,
  input  wire logic [lme_pkg::DATA_W-1:0]     wdata,
  input  wire logic                           wr,
  input  wire logic                           rd,
  output logic      [lme_pkg::DATA_W-1:0]     rdata,
  // Transmit lane events, one-cycle pulses already on sys_clk
  input  wire logic [lme_pkg::LANES-1:0]      tx_adapt_ovf,
  input  wire logic [lme_pkg::LANES-1:0]      tx_align_lost,
  input  wire logic [lme_pkg::LANES-1:0]      tx_phy_unf,
  input  wire logic [lme_pkg::LANES-1:0]      tx_phy_ovf,
  input  wire logic [lme_pkg::LANES-1:0]      tx_ecc_fatal,
  input  wire logic [lme_pkg::LANES-1:0]      tx_ecc_corr,
  // Transmit user-side burst framing
  input  wire logic                           tx_burst_start,
  input  wire logic                           tx_burst_end,
  // Receive side
  input  wire logic [lme_pkg::RX_W-1:0]       rx_err_evt,
  input  wire logic [lme_pkg::LANES-1:0]      rx_sync_seen,
  output logic                                rx_aligned,
  // Interrupt
  output logic                                irq
);
  import lme_pkg::*;

  typedef struct packed {
    logic [TX_W-1:0]   tx_flags;
    logic [TX_W-1:0]   tx_en;
    logic              reinit;
    logic [RX_W-1:0]   rx_flags;
    lme_align_e        st;
    logic [7:0]        gap_cnt;
    logic              gap_arm;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic              aligned;
  } lme_state_s;

  lme_state_s s_reg;
  lme_state_s s_next;

  logic [TX_W-1:0] tx_evt;
  logic [RX_W-1:0] rx_evt;
  logic            gap_err;
  logic            rx_lost;
  logic            all_sync;
  logic            any_sync;

  // Consolidate per-lane events; any lane is enough to raise the flag
  assign all_sync = &rx_sync_seen;
  assign any_sync = |rx_sync_seen;
  // Spacing measured in idle cycles after the end of the previous burst
  assign gap_err  = tx_burst_start && s_reg.gap_arm && (s_reg.gap_cnt < BURST_GAP);
  // Markers not seen by every lane together mean one lane slipped
  assign rx_lost  = (s_reg.st == LME_ALIGNED) && any_sync && !all_sync;

  always_comb begin
    tx_evt                    = '0;
    tx_evt[TX_ADAPT_OVF_BIT]  = |tx_adapt_ovf;
    tx_evt[TX_ALIGN_LOST_BIT] = |tx_align_lost;
    tx_evt[TX_PHY_UNF_BIT]    = |tx_phy_unf;
    tx_evt[TX_PHY_OVF_BIT]    = |tx_phy_ovf;
    tx_evt[TX_ECC_FATAL_BIT]  = |tx_ecc_fatal;
    tx_evt[TX_ECC_CORR_BIT]   = |tx_ecc_corr;
    tx_evt[TX_BURST_GAP_BIT]  = gap_err;
    rx_evt                    = rx_err_evt & RX_FLAG_VALID;
    rx_evt[RX_ALIGN_LOST_BIT] = rx_evt[RX_ALIGN_LOST_BIT] | rx_lost;
  end

  // Next-state logic for the whole block
  always_comb begin
    s_next = s_reg;

    // Write-one-to-clear first, then events OR in so a set beats a clear
    if (wr && addr == TX_ERROR_FLAGS_ADDR) begin
      s_next.tx_flags = s_reg.tx_flags & ~wdata[TX_W-1:0];
    end
    s_next.tx_flags = s_next.tx_flags | tx_evt;
    if (wr && addr == RX_ERROR_FLAGS_ADDR) begin
      s_next.rx_flags = s_reg.rx_flags & ~(wdata[RX_W-1:0] & RX_FLAG_VALID);
    end
    s_next.rx_flags = s_next.rx_flags | rx_evt;

    // Plain read-write controls
    if (wr && addr == TX_ERROR_IRQ_ENABLE_ADDR) begin
      s_next.tx_en = wdata[TX_W-1:0];
    end
    if (wr && addr == RX_LINK_CONTROL_ADDR) begin
      s_next.reinit = wdata[RX_REINIT_BIT];
    end

    // Burst spacing monitor; counter saturates so long idles cost nothing
    if (tx_burst_end) begin
      s_next.gap_cnt = 8'h00;
      s_next.gap_arm = 1'b1;
    end else if (s_reg.gap_arm && s_reg.gap_cnt < BURST_GAP) begin
      s_next.gap_cnt = s_reg.gap_cnt + 8'h01;
    end
    if (tx_burst_start && !tx_burst_end) begin
      s_next.gap_arm = 1'b0;
    end

    // Receive lane alignment; a held restart pins it in idle
    if (s_reg.reinit) begin
      s_next.st = LME_IDLE;
    end else begin
      unique case (s_reg.st)
        LME_IDLE: begin
          s_next.st = LME_SEEK;
        end
        LME_SEEK: begin
          if (all_sync) begin
            s_next.st = LME_ALIGNED;
          end
        end
        LME_ALIGNED: begin
          if (rx_lost) begin
            s_next.st = LME_SEEK;
          end
        end
        default: begin
          s_next.st = LME_IDLE;
        end
      endcase
    end
    s_next.aligned = (s_next.st == LME_ALIGNED);

    // Read data stands only in the cycle after the strobe; unmapped reads zero
    s_next.rdata = '0;
    if (rd) begin
      unique case (addr)
        TX_ERROR_FLAGS_ADDR:      s_next.rdata = {{(DATA_W-TX_W){1'b0}}, s_reg.tx_flags};
        TX_ERROR_IRQ_ENABLE_ADDR: s_next.rdata = {{(DATA_W-TX_W){1'b0}}, s_reg.tx_en};
        RX_LINK_CONTROL_ADDR:     s_next.rdata = {{(DATA_W-1){1'b0}}, s_reg.reinit};
        RX_ERROR_FLAGS_ADDR:      s_next.rdata = {{(DATA_W-RX_W){1'b0}}, s_reg.rx_flags};
        default:                  s_next.rdata = '0;
      endcase
    end

    // Interrupt built from the next flags, so it rises in the same cycle as its flag
    s_next.irq = |(s_next.tx_flags & s_next.tx_en);
  end

  // State register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_reg.tx_flags <= TX_FLAGS_RST;
      s_reg.tx_en    <= TX_EN_RST;
      s_reg.reinit   <= REINIT_RST;
      s_reg.rx_flags <= RX_FLAGS_RST;
      s_reg.st       <= LME_IDLE;
      s_reg.gap_cnt  <= 8'h00;
      s_reg.gap_arm  <= 1'b0;
      s_reg.rdata    <= '0;
      s_reg.irq      <= 1'b0;
      s_reg.aligned  <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign rdata      = s_reg.rdata;
  assign irq        = s_reg.irq;
  assign rx_aligned = s_reg.aligned;

  // Checks
  property p_adapt_set;
    @(posedge sys_clk) disable iff (!resetn)
      |tx_adapt_ovf |=> s_reg.tx_flags[TX_ADAPT_OVF_BIT];
  endproperty
  a_adapt_set: assert property (p_adapt_set) else $error("adapt overflow flag missed");

  property p_align_set;
    @(posedge sys_clk) disable iff (!resetn)
      |tx_align_lost |=> s_reg.tx_flags[TX_ALIGN_LOST_BIT];
  endproperty
  a_align_set: assert property (p_align_set) else $error("alignment lost flag missed");

  property p_unf_set;
    @(posedge sys_clk) disable iff (!resetn)
      |tx_phy_unf |=> s_reg.tx_flags[TX_PHY_UNF_BIT]
        ##1 (s_reg.tx_flags[TX_PHY_UNF_BIT] || $past(wr));
  endproperty
  a_unf_set: assert property (p_unf_set) else $error("phase fifo underflow flag missed");

  property p_ovf_set;
    @(posedge sys_clk) disable iff (!resetn)
      |tx_phy_ovf |=> s_reg.tx_flags[TX_PHY_OVF_BIT];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("phase fifo overflow flag missed");

  property p_w1c;
    @(posedge sys_clk) disable iff (!resetn)
      (wr && addr == TX_ERROR_FLAGS_ADDR && tx_evt == '0)
        |=> s_reg.tx_flags == ($past(s_reg.tx_flags) & ~$past(wdata[TX_W-1:0]));
  endproperty
  a_w1c: assert property (p_w1c) else $error("write-one-to-clear wrong");

  property p_sticky;
    @(posedge sys_clk) disable iff (!resetn)
      !(wr && addr == TX_ERROR_FLAGS_ADDR) |=> (s_reg.tx_flags & $past(s_reg.tx_flags))
        == $past(s_reg.tx_flags);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without a clear");

  property p_set_wins;
    @(posedge sys_clk) disable iff (!resetn)
      (wr && addr == TX_ERROR_FLAGS_ADDR && wdata[TX_PHY_OVF_BIT] && |tx_phy_ovf)
        |=> s_reg.tx_flags[TX_PHY_OVF_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a new event");

  property p_en_write;
    @(posedge sys_clk) disable iff (!resetn)
      (wr && addr == TX_ERROR_IRQ_ENABLE_ADDR) |=> s_reg.tx_en == $past(wdata[TX_W-1:0]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write not stored");

  property p_irq;
    @(posedge sys_clk) disable iff (!resetn)
      ##1 (irq == |(s_reg.tx_flags & s_reg.tx_en));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt disagrees with flags");

  property p_reinit_idle;
    @(posedge sys_clk) disable iff (!resetn)
      s_reg.reinit |=> s_reg.st == LME_IDLE && !rx_aligned
        ##1 (s_reg.reinit || s_reg.st != LME_ALIGNED);
  endproperty
  a_reinit_idle: assert property (p_reinit_idle) else $error("restart did not idle");

  property p_reinit_restart;
    @(posedge sys_clk) disable iff (!resetn)
      ($fell(s_reg.reinit) && s_reg.st == LME_IDLE) |=> s_reg.st == LME_SEEK;
  endproperty
  a_reinit_restart: assert property (p_reinit_restart) else $error("no alignment restart");

  property p_gap;
    @(posedge sys_clk) disable iff (!resetn)
      (tx_burst_end ##1 tx_burst_start) |=> s_reg.tx_flags[TX_BURST_GAP_BIT];
  endproperty
  a_gap: assert property (p_gap) else $error("short burst gap missed");

  property p_ecc;
    @(posedge sys_clk) disable iff (!resetn)
      |tx_ecc_fatal |=> s_reg.tx_flags[TX_ECC_FATAL_BIT];
  endproperty
  a_ecc: assert property (p_ecc) else $error("double-bit error flag missed");

  property p_corr;
    @(posedge sys_clk) disable iff (!resetn)
      |tx_ecc_corr |=> s_reg.tx_flags[TX_ECC_CORR_BIT];
  endproperty
  a_corr: assert property (p_corr) else $error("single-bit error flag missed");

  // Each enable bit alone is enough to raise the interrupt for its flag
  property p_gate_gap;
    @(posedge sys_clk) disable iff (!resetn)
      (s_reg.tx_flags[TX_BURST_GAP_BIT] && s_reg.tx_en[TX_BURST_GAP_BIT]) |-> irq;
  endproperty
  a_gate_gap: assert property (p_gate_gap) else $error("burst gap interrupt missing");

  property p_gate_fatal;
    @(posedge sys_clk) disable iff (!resetn)
      (s_reg.tx_flags[TX_ECC_FATAL_BIT] && s_reg.tx_en[TX_ECC_FATAL_BIT]) |-> irq;
  endproperty
  a_gate_fatal: assert property (p_gate_fatal) else $error("double-bit interrupt missing");

  property p_gate_corr;
    @(posedge sys_clk) disable iff (!resetn)
      (s_reg.tx_flags[TX_ECC_CORR_BIT] && s_reg.tx_en[TX_ECC_CORR_BIT]) |-> irq;
  endproperty
  a_gate_corr: assert property (p_gate_corr) else $error("single-bit interrupt missing");

  property p_gate_adapt;
    @(posedge sys_clk) disable iff (!resetn)
      (s_reg.tx_flags[TX_ADAPT_OVF_BIT] && s_reg.tx_en[TX_ADAPT_OVF_BIT]) |-> irq;
  endproperty
  a_gate_adapt: assert property (p_gate_adapt) else $error("adapt interrupt missing");

  property p_gate_align;
    @(posedge sys_clk) disable iff (!resetn)
      (s_reg.tx_flags[TX_ALIGN_LOST_BIT] && s_reg.tx_en[TX_ALIGN_LOST_BIT]) |-> irq;
  endproperty
  a_gate_align: assert property (p_gate_align) else $error("align interrupt missing");

  property p_gate_unf;
    @(posedge sys_clk) disable iff (!resetn)
      (s_reg.tx_flags[TX_PHY_UNF_BIT] && s_reg.tx_en[TX_PHY_UNF_BIT]) |-> irq;
  endproperty
  a_gate_unf: assert property (p_gate_unf) else $error("underflow interrupt missing");

  property p_gate_ovf;
    @(posedge sys_clk) disable iff (!resetn)
      (s_reg.tx_flags[TX_PHY_OVF_BIT] && s_reg.tx_en[TX_PHY_OVF_BIT]) |-> irq;
  endproperty
  a_gate_ovf: assert property (p_gate_ovf) else $error("overflow interrupt missing");

  // Values seen at the first edge after reset is released
  property p_rst_vals;
    @(posedge sys_clk) disable iff (!resetn)
      $rose(resetn) |-> s_reg.tx_flags == TX_FLAGS_RST && s_reg.tx_en == TX_EN_RST
        && s_reg.reinit == REINIT_RST && rdata == '0 && !irq;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("values after reset wrong");

  property p_rx_w1c;
    @(posedge sys_clk) disable iff (!resetn)
      (wr && addr == RX_ERROR_FLAGS_ADDR && rx_evt == '0)
        |=> s_reg.rx_flags == ($past(s_reg.rx_flags) & ~($past(wdata[RX_W-1:0]) & RX_FLAG_VALID));
  endproperty
  a_rx_w1c: assert property (p_rx_w1c) else $error("receive flag clear wrong");

  property p_reinit_wr;
    @(posedge sys_clk) disable iff (!resetn)
      (wr && addr == RX_LINK_CONTROL_ADDR) |=> s_reg.reinit == $past(wdata[RX_REINIT_BIT]);
  endproperty
  a_reinit_wr: assert property (p_reinit_wr) else $error("restart bit not stored");

  // Read data carry the register as it stood at the strobe
  property p_reinit_rd;
    @(posedge sys_clk) disable iff (!resetn)
      (rd && addr == RX_LINK_CONTROL_ADDR)
        |=> rdata == {{(DATA_W-1){1'b0}}, $past(s_reg.reinit)};
  endproperty
  a_reinit_rd: assert property (p_reinit_rd) else $error("restart bit read wrong");

  property p_flags_rd;
    @(posedge sys_clk) disable iff (!resetn)
      (rd && addr == TX_ERROR_FLAGS_ADDR)
        |=> rdata == {{(DATA_W-TX_W){1'b0}}, $past(s_reg.tx_flags)};
  endproperty
  a_flags_rd: assert property (p_flags_rd) else $error("flag read wrong");

  property p_en_rd;
    @(posedge sys_clk) disable iff (!resetn)
      (rd && addr == TX_ERROR_IRQ_ENABLE_ADDR)
        |=> rdata == {{(DATA_W-TX_W){1'b0}}, $past(s_reg.tx_en)};
  endproperty
  a_en_rd: assert property (p_en_rd) else $error("enable read wrong");

  c_irq_rise: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(irq));
  c_aligned:  cover property (@(posedge sys_clk) disable iff (!resetn) $rose(rx_aligned));
  c_set_clr:  cover property (@(posedge sys_clk) disable iff (!resetn)
    wr && addr == TX_ERROR_FLAGS_ADDR && |(wdata[TX_W-1:0] & tx_evt));
  c_gap_err:  cover property (@(posedge sys_clk) disable iff (!resetn) gap_err);
  c_rx_lost:  cover property (@(posedge sys_clk) disable iff (!resetn) rx_lost);

endmodule : lme_regs

`default_nettype wire

/* tb/lme_regs_test.sv */
`default_nettype none

module lme_regs_test import lme_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic              sys_clk;
  logic              resetn;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              wr;
  logic              rd;
  logic [LANES-1:0]  ev [6];
  logic              b_start;
  logic              b_end;
  logic [RX_W-1:0]   rx_err_evt;
  logic [LANES-1:0]  sync_seen;
  logic              rx_aligned;
  logic              irq;
  int                mismatches;
  int                checks_done;

  // Event table is indexed by the flag bit it should set
  lme_regs uut (.sys_clk(sys_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .tx_adapt_ovf(ev[3]), .tx_align_lost(ev[2]), .tx_phy_unf(ev[1]),
    .tx_phy_ovf(ev[0]), .tx_ecc_fatal(ev[5]), .tx_ecc_corr(ev[4]), .tx_burst_start(b_start),
    .tx_burst_end(b_end), .rx_err_evt(rx_err_evt), .rx_sync_seen(sync_seen),
    .rx_aligned(rx_aligned), .irq(irq));

  // Free-running system clock
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t word got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t bit got %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // One-cycle write strobe, released at the edge that takes it
  task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic expect_rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    chk_word(rdata, exp);
  endtask : expect_rd

  task automatic pulse_sync(input logic [3:0] v);
    @(posedge sys_clk);
    sync_seen <= v;
    @(posedge sys_clk);
    sync_seen <= '0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : pulse_sync

  task automatic t_reset;
    expect_rd(TX_ERROR_FLAGS_ADDR, 32'h0);
    expect_rd(TX_ERROR_IRQ_ENABLE_ADDR, 32'h48);
    @(posedge sys_clk);
    #1;
    chk_word(rdata, 32'h0);
    expect_rd(RX_LINK_CONTROL_ADDR, 32'h0);
    // Unmapped writes must not alias onto the enables
    reg_wr(16'h0092, 32'hffff_ffff);
    expect_rd(16'h0092, 32'h0);
    expect_rd(TX_ERROR_IRQ_ENABLE_ADDR, 32'h48);
    chk_bit(irq, 1'b0);
  endtask : t_reset

  task automatic t_events;
    for (int k = 0; k < 6; k++) begin
      @(posedge sys_clk);
      ev[k] <= 4'h1 << (k % 4);
      @(posedge sys_clk);
      ev[k] <= '0;
      expect_rd(TX_ERROR_FLAGS_ADDR, (32'h2 << k) - 32'h1);
    end
    chk_bit(irq, 1'b1);
    // Walk a single enable across every position
    for (int k = 0; k < 7; k++) begin
      reg_wr(TX_ERROR_IRQ_ENABLE_ADDR, 32'h1 << k);
      expect_rd(TX_ERROR_IRQ_ENABLE_ADDR, 32'h1 << k);
      chk_bit(irq, k < 6);
    end
  endtask : t_events

  task automatic t_clear;
    reg_wr(TX_ERROR_FLAGS_ADDR, 32'h0);
    expect_rd(TX_ERROR_FLAGS_ADDR, 32'h3f);
    // Clear of bit 0 collides with a fresh overflow, which must win
    @(posedge sys_clk);
    addr  <= TX_ERROR_FLAGS_ADDR;
    wdata <= 32'h1;
    wr    <= 1'b1;
    ev[0] <= 4'h8;
    @(posedge sys_clk);
    wr    <= 1'b0;
    ev[0] <= '0;
    expect_rd(TX_ERROR_FLAGS_ADDR, 32'h3f);
    reg_wr(TX_ERROR_FLAGS_ADDR, 32'h3e);
    expect_rd(TX_ERROR_FLAGS_ADDR, 32'h01);
    reg_wr(TX_ERROR_FLAGS_ADDR, 32'h01);
    expect_rd(TX_ERROR_FLAGS_ADDR, 32'h0);
    chk_bit(irq, 1'b0);
  endtask : t_clear

  // Idle gaps from zero up to one below the minimum, and exactly at the minimum
  task automatic t_gap;
    for (int idle = 0; idle <= BURST_GAP; idle++) begin
      reg_wr(TX_ERROR_FLAGS_ADDR, 32'h7f);
      @(posedge sys_clk);
      b_end <= 1'b1;
      @(posedge sys_clk);
      b_end <= 1'b0;
      repeat (idle) @(posedge sys_clk);
      b_start <= 1'b1;
      @(posedge sys_clk);
      b_start <= 1'b0;
      expect_rd(TX_ERROR_FLAGS_ADDR, (idle < BURST_GAP) ? 32'h40 : 32'h0);
      chk_bit(irq, idle < BURST_GAP);
    end
  endtask : t_gap

  task automatic t_reinit;
    pulse_sync(4'hf);
    chk_bit(rx_aligned, 1'b1);
    reg_wr(RX_LINK_CONTROL_ADDR, 32'h1);
    repeat (2) @(posedge sys_clk);
    #1;
    chk_bit(rx_aligned, 1'b0);
    // Markers while the restart is held must not realign
    pulse_sync(4'hf);
    chk_bit(rx_aligned, 1'b0);
    expect_rd(RX_LINK_CONTROL_ADDR, 32'h1);
    reg_wr(RX_LINK_CONTROL_ADDR, 32'h0);
    repeat (2) @(posedge sys_clk);
    pulse_sync(4'hf);
    chk_bit(rx_aligned, 1'b1);
  endtask : t_reinit

  // Partial markers while aligned, then every receive error event at once
  task automatic t_rx;
    pulse_sync(4'h3);
    chk_bit(rx_aligned, 1'b0);
    expect_rd(RX_ERROR_FLAGS_ADDR, 32'h40);
    @(posedge sys_clk);
    rx_err_evt <= 11'h7ff;
    @(posedge sys_clk);
    rx_err_evt <= 11'h000;
    expect_rd(RX_ERROR_FLAGS_ADDR, 32'h77e);
    reg_wr(RX_ERROR_FLAGS_ADDR, 32'h40);
    expect_rd(RX_ERROR_FLAGS_ADDR, 32'h73e);
    reg_wr(RX_ERROR_FLAGS_ADDR, 32'hffff_ffff);
    expect_rd(RX_ERROR_FLAGS_ADDR, 32'h0);
    chk_bit(irq, 1'b0);
  endtask : t_rx

  // Hang guard, far beyond the fewer than two hundred cycles of the sequence
  initial begin
    #200us;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    mismatches  = 0;
    checks_done = 0;
    resetn      = 1'b0;
    addr        = '0;
    wdata       = '0;
    wr          = 1'b0;
    rd          = 1'b0;
    b_start     = 1'b0;
    b_end       = 1'b0;
    rx_err_evt  = '0;
    sync_seen   = '0;
    for (int k = 0; k < 6; k++) ev[k] = '0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_events();
    t_clear();
    t_gap();
    t_reinit();
    t_rx();
    tally_and_finish();
  end

endmodule : lme_regs_test

`default_nettype wire
